// ---- core/dsw_data_space_map.sv ----
// dsw_data_space_map: data-space decode, hardware registers, ROM window and return stack.
// Assumes the core issues one-cycle read/write strobes on CLK and program memory
// answers PM_ADDR combinationally within the same cycle; port pins are asynchronous.
`timescale 1ns/1ps
module dsw_data_space_map (
  input  wire logic                    CLK,
  input  wire logic                    SYS_RST,
  input  wire dsw_pkg::dsw_req_t       DS_REQ,
  output dsw_pkg::dsw_rsp_t            DS_RSP,
  output logic [dsw_pkg::PADDR_W-1:0]  PM_ADDR,
  input  wire logic [7:0]              PM_DATA,
  input  wire logic [7:0]              PORT_A_PIN_IN,
  input  wire logic [7:0]              PORT_B_PIN_IN,
  output dsw_pkg::dsw_port_drv_t       PORT_A_DRV,
  output dsw_pkg::dsw_port_drv_t       PORT_B_DRV,
  output logic [7:0]                   IRQ_OPTIONS,
  input  wire logic [7:0]              CONV_RESULT,
  input  wire logic [7:0]              CONV_STATUS,
  output logic [7:0]                   CONV_CTRL,
  output logic [7:0]                   TMR_PRESCALE,
  output logic [7:0]                   TMR_DOWNCOUNT,
  output logic [7:0]                   TMR_STATUS,
  output logic [7:0]                   WDG_COUNT,
  output logic [7:0]                   IDX_FIRST,
  output logic [7:0]                   IDX_SECOND,
  output logic [7:0]                   SDIR_FIRST,
  output logic [7:0]                   SDIR_SECOND,
  output logic [7:0]                   ACC_VALUE,
  input  wire logic                    ACC_LD,
  input  wire logic [7:0]              ACC_LD_DATA,
  input  wire logic                    STK_PUSH,
  input  wire logic                    STK_POP,
  input  wire logic [dsw_pkg::PADDR_W-1:0] STK_PUSH_ADDR,
  output logic [dsw_pkg::PADDR_W-1:0]  STK_TOP,
  output logic                         STK_EMPTY,
  output logic                         STK_FULL
);
  import dsw_pkg::*;

  logic [BLK_W-1:0] win_blk_r;
  logic             win_pend_r;
  logic [7:0]       pa_s1_r;
  logic [7:0]       pa_s2_r;
  logic [7:0]       pb_s1_r;
  logic [7:0]       pb_s2_r;
  logic [7:0]       pa_latch_r;
  logic [7:0]       pb_latch_r;
  logic [7:0]       pa_dir_r;
  logic [7:0]       pb_dir_r;
  logic [7:0]       pa_opt_r;
  logic [7:0]       pb_opt_r;
  logic [7:0]       irq_opt_r;
  logic [7:0]       conv_ctrl_r;
  logic [7:0]       tmr_psc_r;
  logic [7:0]       tmr_cnt_r;
  logic [7:0]       tmr_stat_r;
  logic [7:0]       wdg_r;
  logic [7:0]       idx_first_r;
  logic [7:0]       idx_second_r;
  logic [7:0]       sdir_first_r;
  logic [7:0]       sdir_second_r;
  logic [7:0]       acc_r;
  logic [7:0]       rdata_nxt;
  logic             in_win;
  logic             wr_en;

  assign in_win = (DS_REQ.addr >= WIN_LO_ADDR) && (DS_REQ.addr <= WIN_HI_ADDR);
  assign wr_en  = DS_REQ.wr && !in_win;

  // two-stage synchronisers for the pin levels
  always_ff @(posedge CLK) begin
    pa_s1_r <= PORT_A_PIN_IN;
    pa_s2_r <= pa_s1_r;
    pb_s1_r <= PORT_B_PIN_IN;
    pb_s2_r <= pb_s1_r;
  end

  // window block select: write-only, keeps its value through reset
  always_ff @(posedge CLK) begin
    if (wr_en && DS_REQ.addr == WIN_SEL_ADDR) begin
      win_blk_r <= DS_REQ.wdata[BLK_W-1:0];
    end
  end

  // window read: present program address, then return the byte a cycle later
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      PM_ADDR    <= '0;
      win_pend_r <= 1'b0;
    end else begin
      win_pend_r <= DS_REQ.rd && in_win;
      if (DS_REQ.rd && in_win) begin
        PM_ADDR <= {win_blk_r, DS_REQ.addr[WOFS_W-1:0]};
      end
    end
  end

  // port data, direction and option registers
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pa_latch_r <= PORT_RST;
      pb_latch_r <= PORT_RST;
      pa_dir_r   <= PORT_RST;
      pb_dir_r   <= PORT_RST;
      pa_opt_r   <= PORT_RST;
      pb_opt_r   <= PORT_RST;
    end else if (wr_en) begin
      unique case (DS_REQ.addr)
        PA_LATCH_ADDR: pa_latch_r <= DS_REQ.wdata;
        PB_LATCH_ADDR: pb_latch_r <= DS_REQ.wdata;
        PA_DIR_ADDR:   pa_dir_r   <= DS_REQ.wdata;
        PB_DIR_ADDR:   pb_dir_r   <= DS_REQ.wdata;
        PA_OPT_ADDR:   pa_opt_r   <= DS_REQ.wdata;
        PB_OPT_ADDR:   pb_opt_r   <= DS_REQ.wdata;
        default: begin
        end
      endcase
    end
  end

  // converter control: write-only bits from the core, read-only bits from the converter
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      conv_ctrl_r <= CONV_CTRL_RST;
    end else if (wr_en && DS_REQ.addr == CONV_CTRL_ADDR) begin
      conv_ctrl_r <= (DS_REQ.wdata & CONV_WO_MASK) | (CONV_STATUS & CONV_RO_MASK);
    end else begin
      conv_ctrl_r <= (conv_ctrl_r & CONV_WO_MASK) | (CONV_STATUS & CONV_RO_MASK);
    end
  end

  // timer and watchdog registers
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      tmr_psc_r  <= TMR_PSC_RST;
      tmr_cnt_r  <= TMR_CNT_RST;
      tmr_stat_r <= TMR_STAT_RST;
      wdg_r      <= WDG_RST;
    end else if (wr_en) begin
      unique case (DS_REQ.addr)
        TMR_PSC_ADDR:  tmr_psc_r  <= DS_REQ.wdata;
        TMR_CNT_ADDR:  tmr_cnt_r  <= DS_REQ.wdata;
        TMR_STAT_ADDR: tmr_stat_r <= DS_REQ.wdata;
        WDG_ADDR:      wdg_r      <= DS_REQ.wdata;
        default: begin
        end
      endcase
    end
  end

  // core registers and interrupt options: no reset, contents undefined after reset
  always_ff @(posedge CLK) begin
    if (wr_en) begin
      unique case (DS_REQ.addr)
        IDX_FIRST_ADDR:   idx_first_r   <= DS_REQ.wdata;
        IDX_SECOND_ADDR:  idx_second_r  <= DS_REQ.wdata;
        SDIR_FIRST_ADDR:  sdir_first_r  <= DS_REQ.wdata;
        SDIR_SECOND_ADDR: sdir_second_r <= DS_REQ.wdata;
        IRQ_OPT_ADDR:     irq_opt_r     <= DS_REQ.wdata;
        default: begin
        end
      endcase
    end
  end

  // accumulator: a data-space write takes priority over the core's own load
  always_ff @(posedge CLK) begin
    if (wr_en && DS_REQ.addr == ACC_ADDR) begin
      acc_r <= DS_REQ.wdata;
    end else if (ACC_LD) begin
      acc_r <= ACC_LD_DATA;
    end
  end

  // read mux; write-only and reserved locations read as a fixed value
  always_comb begin
    rdata_nxt = RSVD_READ_VAL;
    unique case (DS_REQ.addr)
      IDX_FIRST_ADDR:   rdata_nxt = idx_first_r;
      IDX_SECOND_ADDR:  rdata_nxt = idx_second_r;
      SDIR_FIRST_ADDR:  rdata_nxt = sdir_first_r;
      SDIR_SECOND_ADDR: rdata_nxt = sdir_second_r;
      PA_LATCH_ADDR:    rdata_nxt = (pa_dir_r & pa_latch_r) | (~pa_dir_r & pa_s2_r);
      PB_LATCH_ADDR:    rdata_nxt = (pb_dir_r & pb_latch_r) | (~pb_dir_r & pb_s2_r);
      PA_DIR_ADDR:      rdata_nxt = pa_dir_r;
      PB_DIR_ADDR:      rdata_nxt = pb_dir_r;
      PA_OPT_ADDR:      rdata_nxt = pa_opt_r;
      PB_OPT_ADDR:      rdata_nxt = pb_opt_r;
      CONV_RES_ADDR:    rdata_nxt = CONV_RESULT;
      CONV_CTRL_ADDR:   rdata_nxt = conv_ctrl_r & CONV_RO_MASK;
      TMR_PSC_ADDR:     rdata_nxt = tmr_psc_r;
      TMR_CNT_ADDR:     rdata_nxt = tmr_cnt_r;
      TMR_STAT_ADDR:    rdata_nxt = tmr_stat_r;
      WDG_ADDR:         rdata_nxt = wdg_r;
      ACC_ADDR:         rdata_nxt = acc_r;
      default: begin
      end
    endcase
  end

  // answer: registers one cycle after the strobe, window bytes two cycles after
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      DS_RSP <= '0;
    end else if (win_pend_r) begin
      DS_RSP.valid <= 1'b1;
      DS_RSP.data  <= PM_DATA;
    end else if (DS_REQ.rd && !in_win) begin
      DS_RSP.valid <= 1'b1;
      DS_RSP.data  <= rdata_nxt;
    end else begin
      DS_RSP.valid <= 1'b0;
    end
  end

  // pin drive and peripheral control outputs, each from its own flop
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      PORT_A_DRV <= '0;
      PORT_B_DRV <= '0;
    end else begin
      PORT_A_DRV <= '{out: pa_latch_r, oe: pa_dir_r, opt: pa_opt_r};
      PORT_B_DRV <= '{out: pb_latch_r, oe: pb_dir_r, opt: pb_opt_r};
    end
  end

  always_ff @(posedge CLK) begin
    IRQ_OPTIONS   <= irq_opt_r;
    CONV_CTRL     <= conv_ctrl_r & CONV_WO_MASK;
    TMR_PRESCALE  <= tmr_psc_r;
    TMR_DOWNCOUNT <= tmr_cnt_r;
    TMR_STATUS    <= tmr_stat_r;
    WDG_COUNT     <= wdg_r;
    IDX_FIRST     <= idx_first_r;
    IDX_SECOND    <= idx_second_r;
    SDIR_FIRST    <= sdir_first_r;
    SDIR_SECOND   <= sdir_second_r;
    ACC_VALUE     <= acc_r;
  end

  dsw_return_stack #(
    .DEPTH (STK_DEPTH),
    .W     (PADDR_W)
  ) u_stack (
    .CLK           (CLK),
    .SYS_RST       (SYS_RST),
    .STK_PUSH      (STK_PUSH),
    .STK_POP       (STK_POP),
    .STK_PUSH_ADDR (STK_PUSH_ADDR),
    .STK_TOP       (STK_TOP),
    .STK_EMPTY     (STK_EMPTY),
    .STK_FULL      (STK_FULL)
  );

  default clocking dcb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  sequence s_win_read;
    DS_REQ.rd && DS_REQ.addr[7:6] == 2'b01;
  endsequence

  sequence s_reg_read(logic [7:0] a);
    DS_REQ.rd && DS_REQ.addr == a;
  endsequence

  sequence s_sel_write;
    DS_REQ.wr && DS_REQ.addr == WIN_SEL_ADDR;
  endsequence

  a_win_addr_form: assert property (
    s_win_read |=> PM_ADDR == {$past(win_blk_r), $past(DS_REQ.addr[5:0])})
    else $error("window read drove wrong program address");

  a_win_data_ret: assert property (
    s_win_read ##1 1'b1 |=> DS_RSP.valid && DS_RSP.data == $past(PM_DATA))
    else $error("window byte not returned two cycles after read");

  a_win_no_early: assert property (
    s_win_read |=> !DS_RSP.valid || $past(win_pend_r))
    else $error("window read answered too early");

  a_win_sel_write: assert property (
    s_sel_write |=> win_blk_r == $past(DS_REQ.wdata[5:0]))
    else $error("block select not loaded from low six bits");

  a_win_write_void: assert property (
    DS_REQ.wr && in_win |=> ($stable(acc_r) || $past(ACC_LD)) && $stable(pa_latch_r) &&
      $stable(win_blk_r))
    else $error("write into window changed a register");

  a_port_read_mix: assert property (
    s_reg_read(PA_LATCH_ADDR) |=> DS_RSP.valid && DS_RSP.data ==
      (($past(pa_dir_r) & $past(pa_latch_r)) | (~$past(pa_dir_r) & $past(pa_s2_r))))
    else $error("port read mixed latch and pins wrongly");

  a_timer_reset_val: assert property (
    $fell(SYS_RST) |-> tmr_psc_r == 8'h7F && tmr_cnt_r == 8'hFF && tmr_stat_r == 8'h00)
    else $error("timer registers not at reset values");

  a_conv_reset_val: assert property (
    $fell(SYS_RST) |-> conv_ctrl_r == 8'h40)
    else $error("converter control not at reset value");

  a_core_reg_back: assert property (
    DS_REQ.wr && DS_REQ.addr == SDIR_SECOND_ADDR ##2 s_reg_read(SDIR_SECOND_ADDR)
      |=> DS_RSP.data == $past(DS_REQ.wdata, 3))
    else $error("short direct register did not read back");

  a_acc_alias_wr: assert property (
    DS_REQ.wr && DS_REQ.addr == ACC_ADDR |=> acc_r == $past(DS_REQ.wdata) ##1
      ACC_VALUE == $past(acc_r))
    else $error("accumulator alias write lost");

  a_sel_ignore_top: assert property (
    s_sel_write ##1 !DS_REQ.wr ##1 s_win_read
      |=> PM_ADDR[11:6] == $past(DS_REQ.wdata[5:0], 3))
    else $error("select bits 7:6 reached the program address");

  a_reg_read_ans: assert property (
    DS_REQ.rd && !in_win |=> DS_RSP.valid)
    else $error("register read not answered next cycle");

  a_rsvd_read_val: assert property (
    s_reg_read(8'hC3) |=> DS_RSP.valid && DS_RSP.data == RSVD_READ_VAL)
    else $error("reserved location read a stored value");

  a_conv_wo_zero: assert property (
    s_reg_read(CONV_CTRL_ADDR) |=> (DS_RSP.data & CONV_WO_MASK) == 8'h00)
    else $error("converter write-only bits read back");

  a_stack_top_push: assert property (
    STK_PUSH |=> STK_TOP == $past(STK_PUSH_ADDR))
    else $error("pushed address not on top of stack");

endmodule

// ---- core/dsw_pkg.sv ----
// dsw_pkg: constants and carrier types for the data-space register map and ROM window.
// Assumes an 8-bit data space, a 12-bit program space and a single core clock.
package dsw_pkg;

  localparam int unsigned DATA_W    = 8;
  localparam int unsigned DADDR_W   = 8;
  localparam int unsigned PADDR_W   = 12;
  localparam int unsigned BLK_W     = 6;
  localparam int unsigned WOFS_W    = 6;
  localparam int unsigned STK_DEPTH = 6;

  // window span in data space
  localparam logic [7:0] WIN_LO_ADDR      = 8'h40;
  localparam logic [7:0] WIN_HI_ADDR      = 8'h7F;

  // register offsets
  localparam logic [7:0] IDX_FIRST_ADDR   = 8'h80;
  localparam logic [7:0] IDX_SECOND_ADDR  = 8'h81;
  localparam logic [7:0] SDIR_FIRST_ADDR  = 8'h82;
  localparam logic [7:0] SDIR_SECOND_ADDR = 8'h83;
  localparam logic [7:0] PA_LATCH_ADDR    = 8'hC0;
  localparam logic [7:0] PB_LATCH_ADDR    = 8'hC1;
  localparam logic [7:0] PA_DIR_ADDR      = 8'hC4;
  localparam logic [7:0] PB_DIR_ADDR      = 8'hC5;
  localparam logic [7:0] IRQ_OPT_ADDR     = 8'hC8;
  localparam logic [7:0] WIN_SEL_ADDR     = 8'hC9;
  localparam logic [7:0] PA_OPT_ADDR      = 8'hCC;
  localparam logic [7:0] PB_OPT_ADDR      = 8'hCD;
  localparam logic [7:0] CONV_RES_ADDR    = 8'hD0;
  localparam logic [7:0] CONV_CTRL_ADDR   = 8'hD1;
  localparam logic [7:0] TMR_PSC_ADDR     = 8'hD2;
  localparam logic [7:0] TMR_CNT_ADDR     = 8'hD3;
  localparam logic [7:0] TMR_STAT_ADDR    = 8'hD4;
  localparam logic [7:0] WDG_ADDR         = 8'hD8;
  localparam logic [7:0] ACC_ADDR         = 8'hFF;

  // reset values
  localparam logic [7:0] PORT_RST         = 8'h00;
  localparam logic [7:0] CONV_CTRL_RST    = 8'h40;
  localparam logic [7:0] TMR_PSC_RST      = 8'h7F;
  localparam logic [7:0] TMR_CNT_RST      = 8'hFF;
  localparam logic [7:0] TMR_STAT_RST     = 8'h00;
  localparam logic [7:0] WDG_RST          = 8'hFE;

  // converter control: read-only status bit 6, the rest write-only
  localparam logic [7:0] CONV_RO_MASK     = 8'h40;
  localparam logic [7:0] CONV_WO_MASK     = 8'hBF;
  localparam logic [7:0] RSVD_READ_VAL    = 8'h00;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dsw_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } dsw_rsp_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] opt;
  } dsw_port_drv_t;

endpackage

// ---- core/dsw_return_stack.sv ----
// dsw_return_stack: six-level 12-bit return-address stack, newest entry on top.
// Assumes push and pop come from the core on CLK; push on a full stack drops the oldest.
`timescale 1ns/1ps
module dsw_return_stack #(
  parameter int unsigned DEPTH = dsw_pkg::STK_DEPTH,
  parameter int unsigned W     = dsw_pkg::PADDR_W
) (
  input  wire logic         CLK,
  input  wire logic         SYS_RST,
  input  wire logic         STK_PUSH,
  input  wire logic         STK_POP,
  input  wire logic [W-1:0] STK_PUSH_ADDR,
  output logic      [W-1:0] STK_TOP,
  output logic              STK_EMPTY,
  output logic              STK_FULL
);
  import dsw_pkg::*;

  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] LVL_MAX = CW'(DEPTH);

  logic [W-1:0]  ent_r [DEPTH];
  logic [CW-1:0] lvl_r;
  logic [CW-1:0] lvl_nxt;

  always_comb begin
    lvl_nxt = lvl_r;
    if (STK_PUSH && !STK_POP && lvl_r != LVL_MAX) begin
      lvl_nxt = lvl_r + CW'(1);
    end else if (STK_POP && !STK_PUSH && lvl_r != '0) begin
      lvl_nxt = lvl_r - CW'(1);
    end
  end

  // entries shift down on push and up on pop; both at once replaces the top
  always_ff @(posedge CLK) begin
    if (STK_PUSH && STK_POP) begin
      ent_r[0] <= STK_PUSH_ADDR;
    end else if (STK_PUSH) begin
      ent_r[0] <= STK_PUSH_ADDR;
      for (int i = 1; i < DEPTH; i++) begin
        ent_r[i] <= ent_r[i-1];
      end
    end else if (STK_POP) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        ent_r[i] <= ent_r[i+1];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      lvl_r     <= '0;
      STK_EMPTY <= 1'b1;
      STK_FULL  <= 1'b0;
    end else begin
      lvl_r     <= lvl_nxt;
      STK_EMPTY <= (lvl_nxt == '0);
      STK_FULL  <= (lvl_nxt == LVL_MAX);
    end
  end

  assign STK_TOP = ent_r[0];

endmodule

// ---- verif/dsw_pm_model.sv ----
// dsw_pm_model: program memory seen by the data-space window, answering combinationally.
// Assumes PM_ADDR is 12 bits; each offset within a block, and each block at one offset, gives a distinct byte pattern.
`timescale 1ns/1ps
module dsw_pm_model (
  input  wire logic [11:0] PM_ADDR,
  output logic      [7:0]  PM_DATA
);
  // block bits fold into the byte so a wrong block base shows up
  assign PM_DATA = PM_ADDR[7:0] ^ {PM_ADDR[11:6], 2'b01} ^ 8'h5A;
endmodule

// ---- verif/tb_top.sv ----
// tb_top: self-checking bench for the data-space map, ROM window and return stack.
// Assumes dsw_pkg is compiled first; inputs change 1 ns after the rising CLK edge.
`timescale 1ns/1ps
module tb_top;
  import dsw_pkg::*;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
  } dsw_row_t;

  logic          CLK;
  logic          SYS_RST;
  dsw_req_t      ds_req;
  dsw_rsp_t      ds_rsp;
  logic [11:0]   pm_addr;
  logic [7:0]    pm_data;
  logic [7:0]    pin_a;
  logic [7:0]    pin_b;
  dsw_port_drv_t drv_a;
  dsw_port_drv_t drv_b;
  logic [7:0]    conv_res;
  logic [7:0]    win_shadow;
  logic [7:0]    irq_opt;
  logic [7:0]    conv_stat;
  logic [7:0]    conv_ctrl;
  logic [7:0]    tmr_psc;
  logic [7:0]    tmr_cnt;
  logic [7:0]    tmr_st;
  logic [7:0]    wdg;
  logic [7:0]    idx_first;
  logic [7:0]    idx_second;
  logic [7:0]    sdir_first;
  logic [7:0]    sdir_second;
  logic [7:0]    acc;
  logic          acc_ld;
  logic [7:0]    acc_ld_data;
  logic          stk_push;
  logic          stk_pop;
  logic [11:0]   stk_push_addr;
  logic [11:0]   stk_top;
  logic          stk_empty;
  logic          stk_full;
  int            num_errors;
  int            n_checks;
  int            cyc;
  logic [5:0]    blks [4] = '{6'h00, 6'h01, 6'h03, 6'h3F};
  // C4/C5 come before C0/C1 so direction is known when the latch reads back
  // port a bits 7:4 stay inputs at their reset direction, so they read back the pin levels
  dsw_row_t      rows [20] = '{
    '{8'h80, 8'hAA, 8'hAA}, '{8'h81, 8'h55, 8'h55}, '{8'h82, 8'h3C, 8'h3C},
    '{8'h83, 8'hC3, 8'hC3}, '{8'hC4, 8'h0F, 8'h0F}, '{8'hC5, 8'h0F, 8'h0F},
    '{8'hC0, 8'h0A, 8'hCA}, '{8'hC1, 8'hA5, 8'h35}, '{8'hCC, 8'h02, 8'h02},
    '{8'hCD, 8'h34, 8'h34}, '{8'hD2, 8'h11, 8'h11}, '{8'hD3, 8'h22, 8'h22},
    '{8'hD4, 8'h33, 8'h33}, '{8'hD8, 8'h44, 8'h44}, '{8'hFF, 8'h9E, 8'h9E},
    '{8'hD0, 8'h12, 8'h9C}, '{8'hD1, 8'hFF, 8'h40}, '{8'hC3, 8'h77, 8'h00},
    '{8'hDA, 8'h77, 8'h00}, '{8'hC8, 8'h66, 8'h00}};
  dsw_row_t      rst_rows [6] = '{
    '{8'hD2, 8'h00, 8'h7F}, '{8'hD3, 8'h00, 8'hFF}, '{8'hD4, 8'h00, 8'h00},
    '{8'hD8, 8'h00, 8'hFE}, '{8'hC4, 8'h00, 8'h00}, '{8'hC0, 8'h00, 8'hC3}};

  dsw_data_space_map dsw_data_space_map_i (
    .CLK(CLK), .SYS_RST(SYS_RST), .DS_REQ(ds_req), .DS_RSP(ds_rsp),
    .PM_ADDR(pm_addr), .PM_DATA(pm_data), .PORT_A_PIN_IN(pin_a), .PORT_B_PIN_IN(pin_b),
    .PORT_A_DRV(drv_a), .PORT_B_DRV(drv_b), .IRQ_OPTIONS(irq_opt), .CONV_RESULT(conv_res),
    .CONV_STATUS(conv_stat), .CONV_CTRL(conv_ctrl), .TMR_PRESCALE(tmr_psc),
    .TMR_DOWNCOUNT(tmr_cnt), .TMR_STATUS(tmr_st), .WDG_COUNT(wdg), .IDX_FIRST(idx_first),
    .IDX_SECOND(idx_second), .SDIR_FIRST(sdir_first), .SDIR_SECOND(sdir_second),
    .ACC_VALUE(acc), .ACC_LD(acc_ld),
    .ACC_LD_DATA(acc_ld_data), .STK_PUSH(stk_push), .STK_POP(stk_pop),
    .STK_PUSH_ADDR(stk_push_addr), .STK_TOP(stk_top), .STK_EMPTY(stk_empty),
    .STK_FULL(stk_full));

  dsw_pm_model dsw_pm_model_i (.PM_ADDR(pm_addr), .PM_DATA(pm_data));

  function automatic logic [7:0] pm_byte(input logic [11:0] a);
    return a[7:0] ^ {a[11:6], 2'b01} ^ 8'h5A;
  endfunction

  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // each bus task starts and ends 1 ns after an edge, with one idle cycle at the end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ds_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge CLK);
    #1;
    ds_req = '0;
    @(posedge CLK);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input int lat);
    int n;
    ds_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge CLK);
    #1;
    ds_req = '0;
    n = 1;
    while (ds_rsp.valid !== 1'b1 && n < 4) begin
      @(posedge CLK);
      #1;
      n++;
    end
    chk($sformatf("read %h data", a), {16'h0, ds_rsp.data}, {16'h0, exp});
    chk($sformatf("read %h latency", a), 24'(n), 24'(lat));
    @(posedge CLK);
    #1;
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      stop_test();
    end
  end

  initial begin
    SYS_RST = 1'b1;
    ds_req = '0;
    pin_a = 8'hC3;
    pin_b = 8'h3C;
    conv_stat = 8'h40;
    conv_res = 8'h9C;
    win_shadow = 8'h00;
    acc_ld = 1'b0;
    acc_ld_data = 8'h00;
    stk_push = 1'b0;
    stk_pop = 1'b0;
    stk_push_addr = 12'h000;
    repeat (12) @(posedge CLK);
    #1;
    SYS_RST = 1'b0;
    @(posedge CLK);
    #1;
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].rdata, 1);
    end
    chk("register copies", {irq_opt, idx_first, acc}, 24'h66AA9E);
    chk("port a drive", drv_a, 24'h0A0F02);
    chk("port b drive", drv_b, 24'hA50F34);
    chk("core copies", {idx_second, sdir_first, sdir_second}, 24'h553CC3);
    chk("timer copies run", {tmr_psc, tmr_cnt, tmr_st}, 24'h112233);
    chk("converter copy run", {8'h0, wdg, conv_ctrl}, 24'h0044BF);
    $display("test register rows done");
    // select written before the first window read, never read back
    foreach (blks[i]) begin
      win_shadow = {2'b00, blks[i]};
      wr(8'hC9, {(i == 3) ? 2'b11 : 2'b00, win_shadow[5:0]});
      rd(8'h40, pm_byte({win_shadow[5:0], 6'h00}), 2);
      rd(8'h7F, pm_byte({blks[i], 6'h3F}), 2);
      chk("window address", {12'h0, pm_addr}, {12'h0, blks[i], 6'h3F});
    end
    wr(8'h45, 8'h00);
    rd(8'h45, pm_byte({6'h3F, 6'h05}), 2);
    $display("test window done");
    wr(8'hC9, 8'h05);
    SYS_RST = 1'b1;
    conv_stat = 8'h00;
    repeat (2) @(posedge CLK);
    #1;
    chk("timer copies", {tmr_psc, tmr_cnt, tmr_st}, 24'h7FFF00);
    chk("watchdog and converter", {8'h0, wdg, conv_ctrl}, 24'h00FE00);
    chk("port a drive reset", drv_a, 24'h000000);
    SYS_RST = 1'b0;
    @(posedge CLK);
    #1;
    foreach (rst_rows[i]) begin
      rd(rst_rows[i].addr, rst_rows[i].rdata, 1);
    end
    rd(8'hD1, 8'h00, 1);
    conv_res = 8'h6B;
    rd(8'hD0, 8'h6B, 1);
    rd(8'h52, pm_byte({6'h05, 6'h12}), 2);
    $display("test reset done");
    acc_ld_data = 8'h3C;
    acc_ld = 1'b1;
    @(posedge CLK);
    #1;
    acc_ld = 1'b0;
    // the registered copy lags the accumulator by one edge
    @(posedge CLK);
    #1;
    chk("accumulator load", {16'h0, acc}, 24'h00003C);
    rd(8'hFF, 8'h3C, 1);
    $display("test accumulator done");
    chk("stack empty", {23'h0, stk_empty}, 24'h1);
    stk_push = 1'b1;
    for (int i = 0; i < 7; i++) begin
      stk_push_addr = 12'hA50 + 12'(i);
      @(posedge CLK);
      #1;
      if (i == 4 || i == 5) chk("stack full", {23'h0, stk_full}, 24'(i == 5));
    end
    stk_push = 1'b0;
    chk("stack top", {12'h0, stk_top}, 24'hA56);
    stk_pop = 1'b1;
    for (int i = 0; i < 6; i++) begin
      @(posedge CLK);
      #1;
      if (i < 5) chk("stack pop", {12'h0, stk_top}, 24'hA55 - 24'(i));
    end
    stk_pop = 1'b0;
    chk("stack drained", {22'h0, stk_empty, stk_full}, 24'h2);
    $display("test stack done");
    stop_test();
  end
endmodule
